// ### logic/mem_map_decode.sv
// Operation
// - Each source owns high/low vector byte pair
// - Higher vector address means higher priority
// - Flag n selects vector at FFFA-2(n-1)
// - Service location reads reset low, write clears
// - Decode 512 RAM bytes at 0040-023F
// - RAM below 0100 reachable by direct addressing
// - Sixteen-bit stack pointer resets to 00FF
// - Interrupt entry pushes exactly five bytes
// - Upper index half is never stacked
// - Subroutine call pushes two return bytes
// - Pointer decrements on push, increments on pull
// - Break status: enable bit7, active bit6
// - Low-voltage status: read-only detector bit7
// - Program and erase selects never both set
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module mem_map_decode
	import memmap_pkg::*;
#(
	parameter logic [7:0] RESET_VECTOR_LOW = 8'h00
)
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// CPU core events
	input wire logic int_take,
	input wire logic software_interrupt,
	input wire logic [IRQ_FLAGS-1:0] irq_flag,
	input wire logic call_take,
	input wire logic pull_take,
	input wire logic sp_load,
	input wire logic [15:0] sp_load_value,
	input wire logic [15:0] cpu_pc,
	input wire logic [7:0] cpu_x,
	input wire logic [7:0] cpu_a,
	input wire logic [7:0] cpu_ccr,
	// Status inputs
	input wire logic low_voltage_detect_output,
	input wire logic break_match,
	// Stack and vector outputs
	output logic [15:0] stack_pointer,
	output logic stack_busy,
	output logic vector_valid,
	output logic [15:0] vector_address,
	output logic [15:0] vector_value,
	// Control outputs
	output logic watchdog_clear,
	output logic program_select,
	output logic erase_select,
	output logic mass_erase,
	output logic high_voltage_enable,
	output logic break_enable,
	output logic break_active,
	output logic [15:0] break_address,
	output logic [7:0] flash_block_protect
);
	// ==============================
	// Storage
	logic [7:0] ram [0:RAM_BYTES-1];
	logic [7:0] vec_mem [0:VECTOR_BYTES-2];
	logic [3:0] flash_control, fc_wr;
	logic [1:0] break_status;
	logic low_voltage_status, rd_pend, wr_pend, take, ram_hit, vec_hit;
	logic pending_any, accept_int, int_active;
	logic [7:0] read_byte;
	logic [15:0] dp_addr, cpu_addr, next_vec, int_vec;
	logic [8:0] ram_idx;
	logic [5:0] vec_idx, sel_idx;

	stack_link_if sl ();
	stack_unit u_stack (
		.hclk(hclk),
		.hresetn(hresetn),
		.sl(sl)
	);

	// ==============================
	// Address phase
	assign cpu_addr = haddr[17:2];
	assign take = hsel && htrans[1] && hready && hreadyout;

	// Data-phase decode of captured address
	assign ram_hit = dp_addr >= RAM_FIRST && dp_addr <= RAM_LAST;
	assign vec_hit = dp_addr >= VECTOR_FIRST && dp_addr < WATCHDOG_SERVICE_IDX;
	assign ram_idx = 9'(dp_addr - RAM_FIRST);
	assign vec_idx = 6'(dp_addr - VECTOR_FIRST);
	assign sel_idx = 6'(int_vec - VECTOR_FIRST);

	// Capture address phase, wait state on reads
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_addr <= 16'h0000;
			rd_pend <= 1'b0;
			wr_pend <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else if (rd_pend)
		begin
			rd_pend <= 1'b0;
			hreadyout <= 1'b1;
		end
		else
		begin
			wr_pend <= take && hwrite;
			rd_pend <= take && !hwrite;
			hreadyout <= !(take && !hwrite);
			if (take)
				dp_addr <= (haddr[31:18] == 14'h0000) ? cpu_addr : 16'h0000;
		end
	end

	// ==============================
	// Read multiplexer
	always_comb
	begin
		read_byte = 8'h00;
		if (ram_hit)
			read_byte = ram[ram_idx];
		else if (vec_hit)
			read_byte = vec_mem[vec_idx];
		else
			unique case (dp_addr)
				FLASH_CONTROL_IDX: read_byte = {4'h0, flash_control};
				BREAK_ADDRESS_HIGH_IDX: read_byte = break_address[15:8];
				BREAK_ADDRESS_LOW_IDX: read_byte = break_address[7:0];
				BREAK_STATUS_CONTROL_IDX:
					read_byte = {break_status, 6'h00};
				LOW_VOLTAGE_STATUS_IDX:
					read_byte = {low_voltage_status, 7'h00};
				FLASH_BLOCK_PROTECT_IDX: read_byte = flash_block_protect;
				WATCHDOG_SERVICE_IDX: read_byte = RESET_VECTOR_LOW;
				default: read_byte = 8'h00;
			endcase
	end

	// Registered read data
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (rd_pend)
			hrdata <= {24'h000000, read_byte};
	end

	// ==============================
	// RAM bytes, one writer at a time
	assign sl.push_ready = !wr_pend;

	always_ff @(posedge hclk)
	begin
		if (wr_pend && ram_hit)
			ram[ram_idx] <= hwdata[7:0];
		else if (sl.push_valid && sl.push_ready
			&& sl.push_addr >= RAM_FIRST && sl.push_addr <= RAM_LAST)
			ram[9'(sl.push_addr - RAM_FIRST)] <= sl.push_data;
	end

	// Vector bytes and block protect keep contents across reset
	always_ff @(posedge hclk)
	begin
		if (wr_pend && vec_hit)
			vec_mem[vec_idx] <= hwdata[7:0];
		if (wr_pend && dp_addr == FLASH_BLOCK_PROTECT_IDX)
			flash_block_protect <= hwdata[7:0];
	end

	// ==============================
	// Flash control with select interlock
	always_comb
	begin
		fc_wr = FLASH_CONTROL_RESET;
		fc_wr[FC_PROGRAM_BIT] = hwdata[FC_PROGRAM_BIT]
			&& !hwdata[FC_ERASE_BIT]
			&& (flash_control[FC_PROGRAM_BIT]
			|| !flash_control[FC_ERASE_BIT]);
		fc_wr[FC_ERASE_BIT] = hwdata[FC_ERASE_BIT]
			&& !hwdata[FC_PROGRAM_BIT]
			&& (flash_control[FC_ERASE_BIT]
			|| !flash_control[FC_PROGRAM_BIT]);
		fc_wr[FC_MASS_BIT] = hwdata[FC_MASS_BIT];
		fc_wr[FC_HIGH_VOLTAGE_ENABLE_BIT] = hwdata[FC_HIGH_VOLTAGE_ENABLE_BIT]
			&& (fc_wr[FC_PROGRAM_BIT] || fc_wr[FC_ERASE_BIT]);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flash_control <= FLASH_CONTROL_RESET;
		else if (wr_pend && dp_addr == FLASH_CONTROL_IDX)
			flash_control <= fc_wr;
	end

	assign program_select = flash_control[FC_PROGRAM_BIT];
	assign erase_select = flash_control[FC_ERASE_BIT];
	assign mass_erase = flash_control[FC_MASS_BIT];
	assign high_voltage_enable = flash_control[FC_HIGH_VOLTAGE_ENABLE_BIT];

	// ==============================
	// Break registers; a match beats a clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			break_address <= {BREAK_ADDRESS_RESET, BREAK_ADDRESS_RESET};
			break_status <= BREAK_STATUS_RESET;
		end
		else
		begin
			if (wr_pend && dp_addr == BREAK_ADDRESS_HIGH_IDX)
				break_address[15:8] <= hwdata[7:0];
			if (wr_pend && dp_addr == BREAK_ADDRESS_LOW_IDX)
				break_address[7:0] <= hwdata[7:0];
			if (wr_pend && dp_addr == BREAK_STATUS_CONTROL_IDX)
				break_status[1] <= hwdata[BSC_ENABLE_BIT];
			if (break_match)
				break_status[0] <= 1'b1;
			else if (wr_pend && dp_addr == BREAK_STATUS_CONTROL_IDX
				&& !hwdata[BSC_ACTIVE_BIT])
				break_status[0] <= 1'b0;
		end
	end

	assign break_enable = break_status[1];
	assign break_active = break_status[0];
	// Low-voltage detector, read only
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			low_voltage_status <= LOW_VOLTAGE_RESET;
		else
			low_voltage_status <= low_voltage_detect_output;
	end

	// Watchdog service write pulse, nothing stored
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			watchdog_clear <= 1'b0;
		else
			watchdog_clear <= wr_pend
				&& dp_addr == WATCHDOG_SERVICE_IDX;
	end

	// ==============================
	// Vector priority: lowest flag number wins, SOFTWARE_INTERRUPT above all flags
	always_comb
	begin
		next_vec = VECTOR_SWI;
		pending_any = software_interrupt || (irq_flag != 16'h0000);
		if (!software_interrupt)
			for (int n = IRQ_FLAGS; n >= 1; n--)
				if (irq_flag[n-1])
					next_vec = VECTOR_IRQ_ONE - 16'(2 * (n - 1));
	end

	assign accept_int = int_take && !sl.busy && pending_any;
	// Stack command selection
	always_comb
	begin
		sl.op = op_none;
		if (accept_int)
			sl.op = op_int_entry;
		else if (call_take)
			sl.op = op_call;
		else if (pull_take)
			sl.op = op_pull;
		else if (sp_load)
			sl.op = op_load;
	end

	assign sl.load_value = sp_load_value;
	assign sl.pc = cpu_pc;
	assign sl.x = cpu_x;
	assign sl.a = cpu_a;
	assign sl.ccr = cpu_ccr;
	assign stack_pointer = sl.sp;
	assign stack_busy = sl.busy;
	// Latch chosen vector, present it after the frame
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			int_active <= 1'b0;
			int_vec <= VECTOR_RESET;
			vector_valid <= 1'b0;
			vector_address <= VECTOR_RESET;
			vector_value <= 16'h0000;
		end
		else
		begin
			vector_valid <= 1'b0;
			if (accept_int)
			begin
				int_active <= 1'b1;
				int_vec <= next_vec;
			end
			else if (sl.frame_done && int_active)
			begin
				int_active <= 1'b0;
				vector_valid <= 1'b1;
				vector_address <= int_vec;
				vector_value <= {vec_mem[sel_idx],
					vec_mem[6'(sel_idx + 6'h01)]};
			end
		end
	end

	// ==============================
	// Checks
	vector_pair_a: assert property (@(posedge hclk) disable iff (!hresetn)
		vector_valid |-> !vector_address[0]
		&& vector_address >= VECTOR_FIRST && vector_address <= VECTOR_SWI)
		else $error("vector address not an even table entry");
	swi_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
		accept_int && software_interrupt |=> int_vec == VECTOR_SWI)
		else $error("software interrupt lost priority");
	flag_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
		accept_int && !software_interrupt && irq_flag[0]
		|=> int_vec == 16'hfffa)
		else $error("first flag did not select its vector");
	timebase_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
		accept_int && !software_interrupt && irq_flag == 16'h8000
		|=> int_vec == 16'hffdc)
		else $error("timebase flag did not select its vector");
	watchdog_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend && dp_addr == WATCHDOG_SERVICE_IDX |=> watchdog_clear
		##1 !watchdog_clear)
		else $error("service write gave no single clear pulse");
	select_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!(program_select && erase_select))
		else $error("program and erase selects both set");
	break_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		break_match |=> break_active)
		else $error("break match not flagged");
	unmapped_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_pend && !ram_hit && !vec_hit && dp_addr < FLASH_CONTROL_IDX
		|=> hreadyout && hrdata == 32'h0)
		else $error("unmapped read returned data");
	page_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_pend && dp_addr >= RAM_FIRST && dp_addr <= PAGE_ZERO_LAST
		|-> ram_hit && int'(ram_idx) < PAGE_ZERO_RAM_BYTES)
		else $error("page zero address missed RAM");

	int_entry_c: cover property (@(posedge hclk) disable iff (!hresetn)
		vector_valid);
	call_done_c: cover property (@(posedge hclk) disable iff (!hresetn)
		sl.frame_done && !int_active);
	push_stall_c: cover property (@(posedge hclk) disable iff (!hresetn)
		sl.push_valid && !sl.push_ready);
endmodule : mem_map_decode

// ### logic/memmap_pkg.sv
package memmap_pkg;
	// ==============================
	// Address map, CPU byte addresses
	localparam logic [15:0] RAM_FIRST = 16'h0040;
	localparam logic [15:0] RAM_LAST = 16'h023f;
	localparam int RAM_BYTES = 512;
	localparam int PAGE_ZERO_RAM_BYTES = 192;
	localparam logic [15:0] PAGE_ZERO_LAST = 16'h00ff;
	localparam logic [15:0] FLASH_CONTROL_IDX = 16'hfe08;
	localparam logic [15:0] BREAK_ADDRESS_HIGH_IDX = 16'hfe09;
	localparam logic [15:0] BREAK_ADDRESS_LOW_IDX = 16'hfe0a;
	localparam logic [15:0] BREAK_STATUS_CONTROL_IDX = 16'hfe0b;
	localparam logic [15:0] LOW_VOLTAGE_STATUS_IDX = 16'hfe0c;
	localparam logic [15:0] FLASH_BLOCK_PROTECT_IDX = 16'hff7e;
	localparam logic [15:0] WATCHDOG_SERVICE_IDX = 16'hffff;
	localparam logic [15:0] VECTOR_FIRST = 16'hffdc;
	localparam logic [15:0] VECTOR_IRQ_ONE = 16'hfffa;
	localparam logic [15:0] VECTOR_SWI = 16'hfffc;
	localparam logic [15:0] VECTOR_RESET = 16'hfffe;
	localparam int VECTOR_BYTES = 36;
	localparam int IRQ_FLAGS = 16;
	// ==============================
	// Field positions
	localparam int FC_PROGRAM_BIT = 0;
	localparam int FC_ERASE_BIT = 1;
	localparam int FC_MASS_BIT = 2;
	localparam int FC_HIGH_VOLTAGE_ENABLE_BIT = 3;
	localparam int BSC_ACTIVE_BIT = 6;
	localparam int BSC_ENABLE_BIT = 7;
	localparam int LVS_DETECT_BIT = 7;
	// ==============================
	// Reset values and frame sizes
	localparam logic [3:0] FLASH_CONTROL_RESET = 4'h0;
	localparam logic [7:0] BREAK_ADDRESS_RESET = 8'h00;
	localparam logic [1:0] BREAK_STATUS_RESET = 2'h0;
	localparam logic LOW_VOLTAGE_RESET = 1'b0;
	localparam logic [15:0] STACK_POINTER_RESET = 16'h00ff;
	localparam logic [2:0] INT_FRAME_BYTES = 3'h5;
	localparam logic [2:0] CALL_FRAME_BYTES = 3'h2;
	// ==============================
	// Stack commands
	typedef enum logic [2:0]
	{
		op_none, op_int_entry, op_call, op_pull, op_load
	} stack_op_t;
endpackage : memmap_pkg

// ### logic/stack_link_if.sv
`timescale 1ns/1ps
interface stack_link_if;
	import memmap_pkg::*;
	stack_op_t op;
	logic [15:0] load_value;
	logic [15:0] pc;
	logic [7:0] x;
	logic [7:0] a;
	logic [7:0] ccr;
	logic push_valid;
	logic push_ready;
	logic [15:0] push_addr;
	logic [7:0] push_data;
	logic busy;
	logic frame_done;
	logic [15:0] sp;
	modport control (output op, load_value, pc, x, a, ccr, push_ready,
		input push_valid, push_addr, push_data, busy, frame_done, sp);
	modport stacker (input op, load_value, pc, x, a, ccr, push_ready,
		output push_valid, push_addr, push_data, busy, frame_done, sp);
endinterface : stack_link_if

// ### logic/stack_unit.sv
`timescale 1ns/1ps
module stack_unit
	import memmap_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Link to the decoder
	stack_link_if.stacker sl
);
	// ==============================
	// Frame shifter
	logic [7:0] frame [0:4];
	logic [2:0] left;
	logic [15:0] sp_start;
	logic [2:0] push_count;
	logic frame_is_int;

	assign sl.push_valid = sl.busy;
	assign sl.push_addr = sl.sp;
	assign sl.push_data = frame[0];

	// Pointer, frame and busy state
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sl.sp <= STACK_POINTER_RESET;
			sl.busy <= 1'b0;
			sl.frame_done <= 1'b0;
			left <= 3'h0;
			for (int i = 0; i < 5; i++)
				frame[i] <= 8'h00;
		end
		else
		begin
			sl.frame_done <= 1'b0;
			if (sl.busy)
			begin
				if (sl.push_ready)
				begin
					sl.sp <= sl.sp - 16'h0001;
					for (int i = 0; i < 4; i++)
						frame[i] <= frame[i + 1];
					left <= left - 3'h1;
					if (left == 3'h1)
					begin
						sl.busy <= 1'b0;
						sl.frame_done <= 1'b1;
					end
				end
			end
			else
			begin
				unique case (sl.op)
					op_int_entry:
					begin
						// PC low, PC high, X, A, CCR; no upper index half
						frame[0] <= sl.pc[7:0];
						frame[1] <= sl.pc[15:8];
						frame[2] <= sl.x;
						frame[3] <= sl.a;
						frame[4] <= sl.ccr;
						left <= INT_FRAME_BYTES;
						sl.busy <= 1'b1;
					end
					op_call:
					begin
						frame[0] <= sl.pc[7:0];
						frame[1] <= sl.pc[15:8];
						left <= CALL_FRAME_BYTES;
						sl.busy <= 1'b1;
					end
					op_pull: sl.sp <= sl.sp + 16'h0001;
					op_load: sl.sp <= sl.load_value;
					op_none: ;
				endcase
			end
		end
	end

	// Checking helpers: pointer and push count since frame start
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sp_start <= STACK_POINTER_RESET;
			push_count <= 3'h0;
			frame_is_int <= 1'b0;
		end
		else if (!sl.busy && sl.op inside {op_int_entry, op_call})
		begin
			sp_start <= sl.sp;
			push_count <= 3'h0;
			frame_is_int <= sl.op == op_int_entry;
		end
		else if (sl.push_valid && sl.push_ready)
			push_count <= push_count + 3'h1;
	end

	// ==============================
	// Checks
	sp_push_a: assert property (@(posedge hclk) disable iff (!hresetn)
		sl.busy && sl.push_ready |=> sl.sp == $past(sl.sp) - 16'h0001)
		else $error("stack pointer did not drop on push");
	sp_pull_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!sl.busy && sl.op == op_pull |=> sl.sp == $past(sl.sp) + 16'h0001)
		else $error("stack pointer did not rise on pull");
	int_frame_a: assert property (@(posedge hclk) disable iff (!hresetn)
		sl.frame_done && frame_is_int |-> push_count == INT_FRAME_BYTES
		&& sp_start - sl.sp == 16'h0005)
		else $error("interrupt frame not five bytes");
	call_frame_a: assert property (@(posedge hclk) disable iff (!hresetn)
		sl.frame_done && !frame_is_int |-> push_count == CALL_FRAME_BYTES
		&& sp_start - sl.sp == 16'h0002)
		else $error("call frame not two bytes");
endmodule : stack_unit

// ### dv/cpu_core_model.sv
`timescale 1ns/1ps
// ==============================
// CPU core side of the stack and vector link
module cpu_core_model
(
	// Clock
	input wire logic hclk,
	// Bench request
	input wire logic req,
	input wire logic [1:0] kind,
	input wire logic [15:0] value,
	// Core command outputs
	output logic int_take = 1'b0,
	output logic call_take = 1'b0,
	output logic pull_take = 1'b0,
	output logic sp_load = 1'b0,
	output logic [15:0] sp_load_value = 16'h0000,
	output logic [15:0] cpu_pc = 16'h0000,
	output logic [7:0] cpu_x = 8'h00,
	output logic [7:0] cpu_a = 8'h00,
	output logic [7:0] cpu_ccr = 8'h00
);
	// One command pulse per request, register values held with it
	always @(posedge hclk)
	begin
		int_take <= req && kind == 2'd0;
		call_take <= req && kind == 2'd1;
		pull_take <= req && kind == 2'd2;
		sp_load <= req && kind == 2'd3;
		if (req)
		begin
			sp_load_value <= value;
			cpu_pc <= value;
			cpu_x <= ~value[7:0];
			cpu_a <= value[15:8] ^ 8'h5a;
			cpu_ccr <= value[7:0] ^ 8'h3c;
		end
		else
		begin
			// Idle values change every cycle so stale data never matches
			sp_load_value <= ~sp_load_value;
			cpu_pc <= ~cpu_pc;
			cpu_x <= ~cpu_x;
			cpu_a <= ~cpu_a;
			cpu_ccr <= ~cpu_ccr;
		end
	end
endmodule : cpu_core_model

// ### dv/memory_map_vector_decode_tb.sv
`timescale 1ns/1ps
module memory_map_vector_decode_tb;
	import memmap_pkg::*;
	// ==============================
	// Signals
	localparam logic [7:0] RV_LOW = 8'ha5;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, stack_busy, vector_valid, watchdog_clear;
	logic [31:0] hrdata;
	logic int_take, call_take, pull_take, sp_load;
	logic [15:0] sp_load_value, cpu_pc, stack_pointer, vector_address;
	logic [15:0] vector_value, break_address;
	logic [7:0] cpu_x, cpu_a, cpu_ccr, flash_block_protect;
	logic program_select, erase_select, mass_erase, high_voltage_enable;
	logic break_enable, break_active;
	logic software_interrupt = 1'b0;
	logic [15:0] irq_flag = 16'h0;
	logic low_voltage_detect_output = 1'b0;
	logic break_match = 1'b0;
	logic req = 1'b0;
	logic [1:0] kind = 2'h0;
	logic [15:0] value = 16'h0;
	logic [31:0] rd_q[$];
	logic [31:0] vec_q[$];
	logic [7:0] vb[0:35];
	logic [7:0] fr[6];
	logic [15:0] ram_a[4] = '{16'h0040, 16'h00bf, 16'h0100, 16'h023f};
	logic [7:0] r, r2;
	logic [15:0] v, f, k;
	logic rd_ph = 1'b0;
	int n_fail = 0;
	int cmp_count = 0;
	int seed = 24;
	// ==============================
	// Design, core model and clock
	always #12.5 hclk = ~hclk;
	mem_map_decode #(.RESET_VECTOR_LOW(RV_LOW)) uut (.hclk, .hresetn,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .int_take,
		.software_interrupt, .irq_flag, .call_take, .pull_take, .sp_load,
		.sp_load_value, .cpu_pc, .cpu_x, .cpu_a, .cpu_ccr,
		.low_voltage_detect_output, .break_match, .stack_pointer,
		.stack_busy, .vector_valid, .vector_address, .vector_value,
		.watchdog_clear, .program_select, .erase_select, .mass_erase,
		.high_voltage_enable, .break_enable, .break_active, .break_address,
		.flash_block_protect);
	cpu_core_model core (.hclk, .req, .kind, .value, .int_take, .call_take,
		.pull_take, .sp_load, .sp_load_value, .cpu_pc, .cpu_x, .cpu_a,
		.cpu_ccr);
	// ==============================
	// Tasks
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
		input string what);
	begin
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
		end
	end
	endtask : cmp
	task automatic cmp_read(input logic [31:0] got, input logic [31:0] exp);
	begin
		cmp(got, exp, "read");
	end
	endtask : cmp_read
	task automatic cmp_vector(input logic [31:0] got, input logic [31:0] exp);
	begin
		cmp(got, exp, "vector");
	end
	endtask : cmp_vector
	task automatic ahb(input logic w, input logic [15:0] a,
		input logic [7:0] d);
	begin
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {14'h0, a, 2'h0};
		hwrite <= w;
		do
			@(posedge hclk);
		while (!hreadyout);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		if (!w)
			rd_q.push_back({24'h0, d});
		do
			@(posedge hclk);
		while (!hreadyout);
	end
	endtask : ahb
	task automatic cmd(input logic [1:0] c, input logic [15:0] val);
	begin
		@(posedge hclk);
		req <= 1'b1;
		kind <= c;
		value <= val;
		@(posedge hclk);
		req <= 1'b0;
		repeat (3) @(posedge hclk);
		for (int i = 0; i < 20 && stack_busy; i++)
			@(posedge hclk);
		repeat (3) @(posedge hclk);
	end
	endtask : cmd
	task automatic results();
	begin
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask : results
	// ==============================
	// Monitor pairing results with the oldest note
	always @(posedge hclk)
	begin
		if (rd_ph && hreadyout)
			cmp_read(hrdata, rd_q.pop_front());
		if (hreadyout)
			rd_ph = hsel && htrans[1] && !hwrite;
		if (vector_valid)
			cmp_vector({vector_address, vector_value}, vec_q.pop_front());
	end
	// Hang guard
	initial
	begin
		repeat (8000) @(posedge hclk);
		n_fail++;
		results();
	end
	// ==============================
	// Main sequence
	initial
	begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		cmp({16'h0, stack_pointer}, 32'h00ff, "sp");
		for (int i = 8; i < 13; i++)
			ahb(1'b0, 16'hfe00 + 16'(i), 8'h00);
		foreach (ram_a[i])
		begin
			r = 8'($random(seed));
			ahb(1'b1, ram_a[i], r);
			ahb(1'b0, ram_a[i], r);
		end
		ahb(1'b1, 16'h0240, 8'h77);
		ahb(1'b0, 16'h0240, 8'h00);
		ahb(1'b0, 16'h003f, 8'h00);
		// Flash control interlock and high-voltage gate
		ahb(1'b1, FLASH_CONTROL_IDX, 8'hf1);
		ahb(1'b0, FLASH_CONTROL_IDX, 8'h01);
		ahb(1'b1, FLASH_CONTROL_IDX, 8'h03);
		ahb(1'b0, FLASH_CONTROL_IDX, 8'h00);
		cmp({30'h0, erase_select, program_select}, 32'h0, "flash");
		ahb(1'b1, FLASH_CONTROL_IDX, 8'h00);
		ahb(1'b1, FLASH_CONTROL_IDX, 8'h0e);
		ahb(1'b0, FLASH_CONTROL_IDX, 8'h0e);
		cmp({28'h0, high_voltage_enable, mass_erase, erase_select,
			program_select}, 32'he, "flash bits");
		ahb(1'b1, FLASH_CONTROL_IDX, 8'h08);
		ahb(1'b0, FLASH_CONTROL_IDX, 8'h00);
		// Break address and status
		r = 8'($random(seed));
		r2 = 8'($random(seed));
		ahb(1'b1, BREAK_ADDRESS_HIGH_IDX, r);
		ahb(1'b1, BREAK_ADDRESS_LOW_IDX, r2);
		ahb(1'b0, BREAK_ADDRESS_LOW_IDX, r2);
		cmp({16'h0, break_address}, {16'h0, r, r2}, "break address");
		ahb(1'b1, BREAK_STATUS_CONTROL_IDX, 8'hbf);
		ahb(1'b0, BREAK_STATUS_CONTROL_IDX, 8'h80);
		break_match <= 1'b1;
		@(posedge hclk);
		break_match <= 1'b0;
		ahb(1'b0, BREAK_STATUS_CONTROL_IDX, 8'hc0);
		cmp({30'h0, break_enable, break_active}, 32'h3, "break");
		ahb(1'b1, BREAK_STATUS_CONTROL_IDX, 8'h00);
		ahb(1'b0, BREAK_STATUS_CONTROL_IDX, 8'h00);
		// Detector bit is read-only
		low_voltage_detect_output <= 1'b1;
		ahb(1'b1, LOW_VOLTAGE_STATUS_IDX, 8'h00);
		ahb(1'b0, LOW_VOLTAGE_STATUS_IDX, 8'h80);
		ahb(1'b1, FLASH_BLOCK_PROTECT_IDX, r);
		ahb(1'b0, FLASH_BLOCK_PROTECT_IDX, r);
		cmp({24'h0, flash_block_protect}, {24'h0, r}, "protect");
		// Service location: write clears counter, read gives vector
		ahb(1'b1, WATCHDOG_SERVICE_IDX, 8'h5a);
		#1 cmp({31'h0, watchdog_clear}, 32'h1, "clear");
		@(posedge hclk);
		#1 cmp({31'h0, watchdog_clear}, 32'h0, "clear");
		ahb(1'b0, WATCHDOG_SERVICE_IDX, RV_LOW);
		for (int i = 0; i < 34; i++)
		begin
			vb[i] = 8'($random(seed));
			ahb(1'b1, VECTOR_FIRST + 16'(i), vb[i]);
		end
		// Stack pointer movement
		cmd(2'd1, 16'h1234);
		cmp({16'h0, stack_pointer}, 32'h00fd, "sp");
		ahb(1'b0, 16'h00ff, 8'h34);
		ahb(1'b0, 16'h00fe, 8'h12);
		cmd(2'd2, 16'h0000);
		cmp({16'h0, stack_pointer}, 32'h00fe, "sp");
		ahb(1'b1, 16'h01eb, 8'hee);
		cmd(2'd3, 16'h01f0);
		cmp({16'h0, stack_pointer}, 32'h01f0, "sp");
		// Software interrupt outranks flags; five-byte frame
		software_interrupt <= 1'b1;
		irq_flag <= 16'($random(seed));
		v = 16'($random(seed));
		vec_q.push_back({VECTOR_SWI, vb[32], vb[33]});
		cmd(2'd0, v);
		cmp({16'h0, stack_pointer}, 32'h01eb, "sp");
		fr = '{v[7:0], v[15:8], ~v[7:0], v[15:8] ^ 8'h5a, v[7:0] ^ 8'h3c,
			8'hee};
		for (int i = 0; i < 6; i++)
			ahb(1'b0, 16'h01f0 - 16'(i), fr[i]);
		// Each flag wins over a random set of lower-priority flags
		software_interrupt <= 1'b0;
		for (int n = 1; n <= IRQ_FLAGS; n++)
		begin
			f = 16'($random(seed)) & ~((16'h1 << (n - 1)) - 16'h1);
			irq_flag <= f | (16'h1 << (n - 1));
			k = 16'hfffa - 16'(2 * (n - 1));
			vec_q.push_back({k, vb[k - VECTOR_FIRST],
				vb[k - VECTOR_FIRST + 16'h1]});
			cmd(2'd0, 16'($random(seed)));
		end
		cmp({16'h0, stack_pointer}, 32'h019b, "sp");
		irq_flag <= 16'h0;
		cmd(2'd0, 16'h5555);
		cmp({16'h0, stack_pointer}, 32'h019b, "sp");
		cmp({31'h0, hresp}, 32'h0, "resp");
		repeat (4) @(posedge hclk);
		results();
	end
endmodule : memory_map_vector_decode_tb
